// file: palette_host.sv
`timescale 1ns/100ps
// Host end: turns one-cycle user commands into I/O cycles, sequencing
// whole palette entries itself so the component order is never broken.
module palette_host (
  input wire logic mclk_i,
  input wire logic rst_i,
  palette_io_if.host io,
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_op_i,
  input wire logic [15:0] cmd_addr_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic [7:0] cmd_index_i,
  input wire logic [17:0] cmd_color_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic [17:0] color_o,
  output logic [7:0] rdata_o
);

  // ------------------------------------------------------------
  // Types and state.
  // ------------------------------------------------------------
  // Ops: 0 raw write, 1 raw read, 2 color write, 3 color read.
  typedef enum logic [2:0] {IDLE, ADDR, XFER, WAIT, FIN} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [1:0] op;
    logic [1:0] step;          // Component index, red first.
    logic [15:0] addr;
    logic [7:0] data;
    logic [7:0] index;
    logic [17:0] color;
    logic wr;
    logic rd;
    logic ready;
    logic done;
    logic [7:0] rdata;
  } state_t;

  state_t s;
  state_t next_s;

  // ------------------------------------------------------------
  // Sequencer.
  // ------------------------------------------------------------
  // One command at a time; nothing else reaches the port during a
  // color sequence.
  always_comb begin
    next_s = s;
    next_s.wr = 1'b0;
    next_s.rd = 1'b0;
    next_s.done = 1'b0;
    case (s.phase)
      IDLE: begin
        if (cmd_valid_i) begin
          next_s.op = cmd_op_i;
          next_s.index = cmd_index_i;
          next_s.color = cmd_color_i;
          next_s.step = 2'h0;
          next_s.ready = 1'b0;
          next_s.data = cmd_data_i;
          next_s.addr = cmd_addr_i;
          if (cmd_op_i == 2'h1) begin
            next_s.rd = 1'b1;
            next_s.phase = WAIT;
          end else if (cmd_op_i == 2'h0) begin
            next_s.wr = 1'b1;
            next_s.phase = FIN;
          end else begin
            next_s.phase = ADDR;
          end
        end
      end
      ADDR: begin
        // Address first: write pointer for loads, read pointer for reads.
        next_s.wr = 1'b1;
        next_s.data = s.index;
        next_s.addr = (s.op == 2'h2) ? palette_pkg::ADDR_WRITE_PTR
                                     : palette_pkg::ADDR_READ_PTR;
        next_s.phase = XFER;
      end
      XFER: begin
        next_s.addr = palette_pkg::ADDR_COMP_DATA;
        if (s.op == 2'h2) begin
          next_s.wr = 1'b1;
          next_s.data = {2'h0, s.color[17:12]};
          next_s.color = {s.color[11:0], 6'h00};
          next_s.phase = (s.step == 2'h2) ? FIN : XFER;
          next_s.step = s.step + 2'h1;
        end else begin
          next_s.rd = 1'b1;
          next_s.phase = WAIT;
        end
      end
      WAIT: begin
        if (io.rvalid) begin
          next_s.rdata = io.rdata;
          next_s.color = {s.color[11:0], io.rdata[5:0]};
          next_s.step = s.step + 2'h1;
          next_s.phase = (s.op == 2'h1 || s.step == 2'h2) ? FIN : XFER;
        end
      end
      FIN: begin
        next_s.done = 1'b1;
        next_s.ready = 1'b1;
        next_s.phase = IDLE;
      end
      default: next_s.phase = IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s <= '0;
      s.phase <= IDLE;
      s.ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign io.addr = s.addr;
  assign io.wdata = s.data;
  assign io.wr = s.wr;
  assign io.rd = s.rd;
  assign cmd_ready_o = s.ready;
  assign done_o = s.done;
  assign color_o = s.color;
  assign rdata_o = s.rdata;

endmodule : palette_host

// file: palette_io_checker.sv
`timescale 1ns/100ps
// ----------------------------------------
// Checks on the host I/O channel.
// ----------------------------------------
module palette_io_checker (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [15:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic [1:0] last_exp; // Expected last palette command.
  logic [7:0] bord_exp; // Shadow of the border register.
  logic [7:0] ext_exp; // Shadow of the writable extended bits.
  // Shadows follow host writes, so reads can be predicted.
  always_ff @(posedge mclk_i) begin
    if (rst_i) last_exp <= 2'h0;
    else if (wr && addr == palette_pkg::ADDR_READ_PTR) last_exp <= 2'h3;
    else if (wr && (addr == 16'h03c8 || addr == 16'h03c9)) last_exp <= 2'h0;
    else if (rd && addr == palette_pkg::ADDR_COMP_DATA) last_exp <= 2'h3;
    if (rst_i) bord_exp <= palette_pkg::BORDER_RESET;
    else if (wr && addr == palette_pkg::ADDR_BORDER) bord_exp <= wdata;
    if (rst_i) ext_exp <= 8'h00;
    else if (wr && addr == palette_pkg::ADDR_EXT_MODE) ext_exp <= wdata & 8'h7c;
  end
  // A plain read of one port, with no write beside it.
  sequence s_rd(logic [15:0] a);
    rd && !wr && addr == a;
  endsequence
  property p_answer; rd && !wr |=> rvalid; endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  property p_cause; rvalid |-> $past(rd); endproperty
  a_cause: assert property (p_cause) else $error("answer without read");
  property p_stand; !rvalid |-> $stable(rdata); endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
  property p_mask; s_rd(16'h03c6) |=> rdata == 8'hff; endproperty
  a_mask: assert property (p_mask) else $error("mask not ff");
  property p_last; s_rd(16'h03c7) |=> rdata[1:0] == last_exp; endproperty
  a_last: assert property (p_last) else $error("last command wrong");
  property p_six; s_rd(16'h03c9) |=> rdata[7:6] == 2'h0; endproperty
  a_six: assert property (p_six) else $error("component over 6 bits");
  property p_ext; s_rd(16'h03dd) |=> rdata == ext_exp; endproperty
  a_ext: assert property (p_ext) else $error("extended readback wrong");
  property p_border; s_rd(16'h03d9) |=> rdata == bord_exp; endproperty
  a_border: assert property (p_border) else $error("border readback wrong");
endmodule : palette_io_checker

// file: palette_io_if.sv
`timescale 1ns/100ps
// Host I/O channel between the processor end and the palette registers.
interface palette_io_if;
  logic [15:0] addr;   // I/O port address.
  logic wr;            // One-cycle write strobe.
  logic rd;            // One-cycle read strobe.
  logic [7:0] wdata;   // Write data.
  logic [7:0] rdata;   // Read data, valid the cycle after rd.
  logic rvalid;        // One-cycle read answer pulse.

  modport device (input addr, input wr, input rd, input wdata, output rdata, output rvalid);
  modport host (output addr, output wr, output rd, output wdata, input rdata, input rvalid);
endinterface : palette_io_if

// file: palette_pkg.sv
package palette_pkg;

  // ------------------------------------------------------------
  // I/O port addresses of the register group.
  // ------------------------------------------------------------
  localparam logic [15:0] ADDR_PIXEL_MASK = 16'h03c6;
  localparam logic [15:0] ADDR_READ_PTR = 16'h03c7;
  localparam logic [15:0] ADDR_WRITE_PTR = 16'h03c8;
  localparam logic [15:0] ADDR_COMP_DATA = 16'h03c9;
  localparam logic [15:0] ADDR_BORDER = 16'h03d9;
  localparam logic [15:0] ADDR_STATUS = 16'h03da;
  localparam logic [15:0] ADDR_EXT_MODE = 16'h03dd;

  // ------------------------------------------------------------
  // Field positions and reset values.
  // ------------------------------------------------------------
  localparam int BORDER_SET_BIT = 5;
  localparam int BORDER_INTENS_BIT = 4;
  localparam int STATUS_VSYNC_BIT = 3;
  localparam int STATUS_DEN_N_BIT = 0;
  localparam int EXT_NOREAD_BIT = 7;
  localparam int EXT_256_BIT = 2;
  localparam logic [7:0] PIXEL_MASK_RESET = 8'hff;
  localparam logic [7:0] BORDER_RESET = 8'h10;
  localparam logic [7:0] EXT_WRITABLE = 8'h7c;
  localparam logic [1:0] LAST_CMD_WRITE = 2'h0;
  localparam logic [1:0] LAST_CMD_READ = 2'h3;

  // ------------------------------------------------------------
  // Palette geometry.
  // ------------------------------------------------------------
  localparam int PAL_ENTRIES = 256;
  localparam int COMP_W = 6;

  // Component sequence red, green, blue.
  typedef enum logic [1:0] {COMP_RED, COMP_GREEN, COMP_BLUE} comp_t;

endpackage : palette_pkg

// file: palette_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Border bit 5 picks color set one.
// - Border bit 4 picks intensified set.
// - Border bits 3..0 give background address.
// - Pixel pair maps to fixed palette addresses.
// - Status read-only: vsync bit3, enable-low bit0.
// - Extended bit 7 reads readback capability.
// - Host sets 256-color bit for mode 13.
// - 256 entries, three 6-bit fields, 8-bit addresses.
// - Entry transfers go red, green, blue.
// - Single and burst loads both supported.
// - Host keeps access sequence uninterrupted.
// - Pixel mask resets to ff, left alone.
// - Read pointer write sets read entry.
// - Read pointer read gives last command.
// - Write pointer write sets load entry.
// - Each transfer carries one 6-bit level.
// - Host writes address then red, green, blue.
// - Reads after read address return R,G,B.
module palette_regs (
  input wire logic mclk_i,
  input wire logic rst_i,
  palette_io_if.device io,
  input wire logic vsync_i,
  input wire logic display_en_n_i,
  input wire logic [1:0] pixel_i,
  output logic [7:0] palette_index_o,
  output logic [17:0] palette_color_o,
  output logic mode_256_o
);

  // ------------------------------------------------------------
  // State.
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pixel_mask;              // Mask, kept but not applied.
    logic [7:0] rd_ptr;                  // Entry returned by data reads.
    logic [7:0] wr_ptr;                  // Entry loaded by data writes.
    palette_pkg::comp_t comp;            // Next component of the transfer.
    logic [1:0] last_cmd;                // Last palette command code.
    logic [11:0] staged;                 // Red and green awaiting blue.
    logic [7:0] border;                  // Border and color set control.
    logic [7:0] ext_mode;                // Extended mode control.
    logic [1:0] vs_meta;                 // Sync pins, first stage.
    logic [1:0] vs_sync;                 // Sync pins, second stage.
    logic [1:0] px_meta;                 // Pixel pins, first stage.
    logic [1:0] px_sync;                 // Pixel pins, second stage.
    logic [7:0] rdata;                   // Read answer.
    logic rvalid;                        // Read answer pulse.
    logic [7:0] index;                   // Looked-up palette address.
    logic [17:0] color;                  // Color from the lookup.
    logic mode_256;                      // 256-color select out.
  } state_t;

  state_t s;
  state_t next_s;
  logic [17:0] pal [palette_pkg::PAL_ENTRIES];
  logic pal_we;
  logic [7:0] pal_wa;
  logic [17:0] pal_wd;
  logic readback_ok;

  // The converter here can always be read back.
  assign readback_ok = 1'b1;

  // ------------------------------------------------------------
  // Next-state logic.
  // ------------------------------------------------------------
  // All register decode and the sequencer live here; palette storage is
  // written from the same decision through pal_we.
  always_comb begin
    logic [5:0] comp_val;
    logic [7:0] addr;
    comp_val = '0;
    addr = '0;
    next_s = s;
    pal_we = 1'b0;
    pal_wa = s.wr_ptr;
    pal_wd = '0;
    next_s.rvalid = 1'b0;
    next_s.vs_meta = {vsync_i, display_en_n_i};
    next_s.vs_sync = s.vs_meta;
    next_s.px_meta = pixel_i;
    next_s.px_sync = s.px_meta;
    if (io.wr) begin
      case (io.addr)
        palette_pkg::ADDR_PIXEL_MASK: begin
          next_s.pixel_mask = io.wdata;
        end
        palette_pkg::ADDR_READ_PTR: begin
          next_s.rd_ptr = io.wdata;
          next_s.comp = palette_pkg::COMP_RED;
          next_s.last_cmd = palette_pkg::LAST_CMD_READ;
        end
        palette_pkg::ADDR_WRITE_PTR: begin
          next_s.wr_ptr = io.wdata;
          next_s.comp = palette_pkg::COMP_RED;
          next_s.last_cmd = palette_pkg::LAST_CMD_WRITE;
        end
        palette_pkg::ADDR_COMP_DATA: begin
          // Only the low six bits carry a level; the upper two are dropped.
          next_s.last_cmd = palette_pkg::LAST_CMD_WRITE;
          case (s.comp)
            palette_pkg::COMP_RED: begin
              next_s.staged[11:6] = io.wdata[5:0];
              next_s.comp = palette_pkg::COMP_GREEN;
            end
            palette_pkg::COMP_GREEN: begin
              next_s.staged[5:0] = io.wdata[5:0];
              next_s.comp = palette_pkg::COMP_BLUE;
            end
            default: begin
              // Whole entry lands at once so the video path never sees half.
              pal_we = 1'b1;
              pal_wd = {s.staged, io.wdata[5:0]};
              next_s.wr_ptr = s.wr_ptr + 8'h01;
              next_s.comp = palette_pkg::COMP_RED;
            end
          endcase
        end
        palette_pkg::ADDR_BORDER: begin
          next_s.border = io.wdata;
        end
        palette_pkg::ADDR_EXT_MODE: begin
          // Bit 7 is read-only, bits 1 and 0 read as zero.
          next_s.ext_mode = io.wdata & palette_pkg::EXT_WRITABLE;
        end
        default: begin
          next_s.rdata = s.rdata;
        end
      endcase
    end else if (io.rd) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = '0;
      case (io.addr)
        palette_pkg::ADDR_PIXEL_MASK: next_s.rdata = s.pixel_mask;
        palette_pkg::ADDR_READ_PTR: next_s.rdata = {6'h00, s.last_cmd};
        palette_pkg::ADDR_WRITE_PTR: next_s.rdata = s.wr_ptr;
        palette_pkg::ADDR_COMP_DATA: begin
          next_s.last_cmd = palette_pkg::LAST_CMD_READ;
          case (s.comp)
            palette_pkg::COMP_RED: begin
              comp_val = pal[s.rd_ptr][17:12];
              next_s.comp = palette_pkg::COMP_GREEN;
            end
            palette_pkg::COMP_GREEN: begin
              comp_val = pal[s.rd_ptr][11:6];
              next_s.comp = palette_pkg::COMP_BLUE;
            end
            default: begin
              comp_val = pal[s.rd_ptr][5:0];
              next_s.rd_ptr = s.rd_ptr + 8'h01;
              next_s.comp = palette_pkg::COMP_RED;
            end
          endcase
          next_s.rdata = {2'h0, comp_val};
        end
        palette_pkg::ADDR_BORDER: next_s.rdata = s.border;
        palette_pkg::ADDR_STATUS: begin
          next_s.rdata[palette_pkg::STATUS_VSYNC_BIT] = s.vs_sync[1];
          next_s.rdata[palette_pkg::STATUS_DEN_N_BIT] = s.vs_sync[0];
        end
        palette_pkg::ADDR_EXT_MODE: begin
          next_s.rdata = s.ext_mode;
          next_s.rdata[palette_pkg::EXT_NOREAD_BIT] = ~readback_ok;
        end
        default: next_s.rdata = 8'h00;
      endcase
    end
    // Four-color lookup: 00 is the border/background entry.
    if (s.px_sync == 2'h0) begin
      addr = {4'h0, s.border[3:0]};
    end else begin
      addr = {4'h0, s.border[palette_pkg::BORDER_INTENS_BIT],
              s.px_sync, s.border[palette_pkg::BORDER_SET_BIT]};
    end
    next_s.index = addr;
    next_s.color = pal[addr];
    next_s.mode_256 = s.ext_mode[palette_pkg::EXT_256_BIT];
  end

  // ------------------------------------------------------------
  // Registers.
  // ------------------------------------------------------------
  // Palette contents have no reset; software loads them after a mode set.
  always_ff @(posedge mclk_i) begin
    if (pal_we) begin
      pal[pal_wa] <= pal_wd;
    end
    if (rst_i) begin
      s <= '0;
      s.pixel_mask <= palette_pkg::PIXEL_MASK_RESET;
      s.border <= palette_pkg::BORDER_RESET;
      s.comp <= palette_pkg::COMP_RED;
    end else begin
      s <= next_s;
    end
  end

  assign io.rdata = s.rdata;
  assign io.rvalid = s.rvalid;
  assign palette_index_o = s.index;
  assign palette_color_o = s.color;
  assign mode_256_o = s.mode_256;

endmodule : palette_regs

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
  typedef struct packed {logic [17:0] val; logic [17:0] msk;} note_t;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic [1:0] cmd_op_i = 2'h0;
  logic [15:0] cmd_addr_i = 16'h0000;
  logic [7:0] cmd_data_i = 8'h00;
  logic [7:0] cmd_index_i = 8'h00;
  logic [17:0] cmd_color_i = 18'h00000;
  logic vsync_i = 1'b0;
  logic display_en_n_i = 1'b1;
  logic [1:0] pixel_i = 2'h0;
  logic cmd_ready_o, done_o, mode_256_o;
  logic [17:0] color_o, palette_color_o;
  logic [7:0] rdata_o, palette_index_o;
  note_t notes[$]; // Expected results, oldest first.
  note_t n;
  logic [17:0] shade [0:15]; // Colors loaded into entries 0 to 15.
  logic [31:0] seed = 32'h01e5;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  palette_io_if io();
  palette_regs palette_regs_inst (.mclk_i(mclk_i), .rst_i(rst_i), .io(io),
    .vsync_i(vsync_i), .display_en_n_i(display_en_n_i), .pixel_i(pixel_i),
    .palette_index_o(palette_index_o), .palette_color_o(palette_color_o),
    .mode_256_o(mode_256_o));
  palette_host palette_host_inst (.mclk_i(mclk_i), .rst_i(rst_i), .io(io),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
    .cmd_data_i(cmd_data_i), .cmd_index_i(cmd_index_i), .cmd_color_i(cmd_color_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .color_o(color_o), .rdata_o(rdata_o));
  palette_io_checker palette_io_checker_inst (.mclk_i(mclk_i), .rst_i(rst_i),
    .addr(io.addr), .wr(io.wr), .rd(io.rd), .wdata(io.wdata), .rdata(io.rdata),
    .rvalid(io.rvalid));
  // 20 MHz clock.
  always #25 mclk_i = ~mclk_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input logic [17:0] seen, input logic [17:0] exp,
                       input logic [17:0] msk);
    compares++;
    if ((seen & msk) !== (exp & msk)) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // One host command; a is the port or the entry, d the byte or the color.
  task automatic cmd(input logic [1:0] op, input logic [15:0] a, input logic [17:0] d,
                     input logic [17:0] e, input logic [17:0] m);
    int k;
    notes.push_back('{e, m});
    cmd_op_i = op;
    cmd_addr_i = a;
    cmd_index_i = a[7:0];
    cmd_data_i = d[7:0];
    cmd_color_i = d;
    for (k = 0; k < 50 && cmd_ready_o !== 1'b1; k++) @(negedge mclk_i);
    cmd_valid_i = 1'b1;
    @(negedge mclk_i);
    cmd_valid_i = 1'b0;
    for (k = 0; k < 60 && done_o !== 1'b1; k++) @(negedge mclk_i);
    // A command that never completes is a failure, not a silent skip.
    if (k == 60) error_cnt++;
    @(negedge mclk_i);
  endtask : cmd
  // Each completion retires the oldest note; a zero mask means nothing to compare.
  // Sampled on the falling edge so the flopped outputs have settled.
  always @(negedge mclk_i) begin
    if (done_o === 1'b1) begin
      n = notes.pop_front();
      if (n.msk != 18'h0) check(cmd_op_i == 2'h3 ? color_o : {10'h0, rdata_o}, n.val, n.msk);
    end
  end
  // A hang ends the run as a failure.
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    int i;
    int s;
    int p;
    logic [7:0] x;
    logic [35:0] c;
    repeat (20) @(negedge mclk_i);
    rst_i = 1'b0;
    cmd(1, 16'h03c6, 0, 18'hff, 18'hff);
    cmd(1, 16'h03d9, 0, 18'h10, 18'hff);
    cmd(0, 16'h03dd, 8'hff, 0, 0);
    cmd(1, 16'h03dd, 0, 18'h7c, 18'hff);
    check(mode_256_o, 1'b1, 18'h1);
    $display("test registers done");
    for (i = 0; i < 4; i++) begin
      vsync_i = i[1];
      display_en_n_i = i[0];
      repeat (4) @(negedge mclk_i);
      cmd(1, 16'h03da, 0, 18'({i[1], 2'h0, i[0]}), 18'h09);
    end
    $display("test status done");
    c = 36'({rnd(), rnd()});
    cmd(0, 16'h03c8, 8'hff, 0, 0);
    cmd(0, 16'h03c9, 8'h3f, 0, 0);
    cmd(0, 16'h03c8, 8'hff, 0, 0);
    for (i = 0; i < 6; i++) cmd(0, 16'h03c9, {2'h3, c[35 - 6 * i -: 6]}, 0, 0);
    cmd(3, 16'h00ff, 0, c[35:18], 18'h3ffff);
    cmd(3, 16'h0000, 0, c[17:0], 18'h3ffff);
    cmd(0, 16'h03c7, 8'hff, 0, 0);
    cmd(1, 16'h03c9, 0, c[35:30], 18'hff);
    cmd(1, 16'h03c7, 0, 18'h3, 18'h3);
    $display("test burst done");
    for (i = 0; i < 16; i++) begin
      shade[i] = 18'(rnd());
      cmd(2, 16'(i), shade[i], 0, 0);
    end
    cmd(1, 16'h03c7, 0, 18'h0, 18'h3);
    for (i = 0; i < 16; i++) cmd(3, 16'(i), 0, shade[i], 18'h3ffff);
    $display("test palette done");
    for (s = 0; s < 4; s++) begin
      cmd(0, 16'h03d9, {2'h0, s[0], s[1], 4'h5}, 0, 0);
      for (p = 0; p < 4; p++) begin
        pixel_i = p[1:0];
        repeat (6) @(negedge mclk_i);
        x = (p == 0) ? 8'h05 : {4'h0, s[1], p[1:0], s[0]};
        check({10'h0, palette_index_o}, {10'h0, x}, 18'hff);
        check(palette_color_o, shade[x[3:0]], 18'h3ffff);
      end
    end
    $display("test color sets done");
    wrap_up();
  end
endmodule : testbench
